// ### dv/nacd_checker_assertions.sv
// checker on the decoder's control outputs and bus answer
`timescale 1ns/1ps
module nacd_checker (
    input wire logic                i_clk_sys,
    input wire logic                i_rst,
    input wire logic                i_hsel,
    input wire logic [31:0]         i_haddr,
    input wire logic [1:0]          i_htrans,
    input wire logic                i_hwrite,
    input wire logic [31:0]         i_hwdata,
    input wire logic                i_hready,
    input wire logic                o_hresp,
    input wire nacd_pkg::nacd_ctl_s o_ctl
);
    import nacd_pkg::*;
    logic [1:0] live;
    // ====
    // the reset value of o_ctl is no decode, so wait two edges
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) live <= 2'h0;
        else live <= {live[0], 1'b1};
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // ======================================================================
    // soft-test write of the continue code, address then data phase
    sequence seq_next_wr_s;
        i_hsel && i_hready && i_htrans == 2'h2 && i_hwrite &&
        i_haddr == 32'h0 ##1 i_hready && i_hwdata[5:0] == 6'h0E;
    endsequence
    // ======================================================================
    // control output and bus response properties
    map_pl_excl_a: assert property (
        live[1] |-> (o_ctl[1] || o_ctl[0]))
        else $error("map and pipeline enables both active");
    map_jump_a: assert property (
        live[1] && !o_ctl[1] |-> o_ctl == 8'hFD)
        else $error("mapped jump outputs wrong");
    vec_hold_a: assert property (
        live[1] && o_ctl[1] && o_ctl[0] |-> o_ctl[5:2] == 4'hF)
        else $error("vector jump does not hold");
    push_src_a: assert property (
        live[1] && !o_ctl[5] && o_ctl[4]
        |-> o_ctl[7:6] != 2'b10 && o_ctl[2])
        else $error("push with bad source or count");
    pop_src_a: assert property (
        live[1] && !o_ctl[5] && !o_ctl[4]
        |-> o_ctl[3:2] == 2'b11 && o_ctl[7:6] != 2'b01)
        else $error("pop with bad source or count");
    zero_cnt_a: assert property (
        live[1] && o_ctl[3:2] == 2'b00 |-> o_ctl == 8'hF2)
        else $error("zero jump outputs wrong");
    dec_src_a: assert property (
        live[1] && o_ctl[3:2] == 2'b10 |-> o_ctl[5] && o_ctl[7])
        else $error("decrement with bad source or stack");
    load_src_a: assert property (
        live[1] && o_ctl[3:2] == 2'b01 |-> o_ctl[7:6] == 2'b00)
        else $error("load without program counter source");
    resp_okay_a: assert property (
        o_hresp == 1'b0)
        else $error("bus response not okay");
    seq_write_a: assert property (
        seq_next_wr_s |-> ##2 o_ctl == 8'h3E)
        else $error("continue write not decoded");
endmodule // nacd_checker

// ### dv/nacd_seq_model.sv
// sequencer side model: stack depth, loop counter, test line
`timescale 1ns/1ps
module nacd_seq_model #(
    parameter int LOAD_VAL = 5
) (
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst,
    input  wire nacd_pkg::nacd_ctl_s i_ctl,
    input  wire logic                i_cond,
    output      logic                o_test_cond,
    output      logic [7:0]          o_count,
    output      logic [3:0]          o_depth
);
    import nacd_pkg::*;
    logic [3:0] depth;
    logic [7:0] count;
    assign o_count = count;
    assign o_depth = depth;
    // ====
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            depth <= 4'h0;
            count <= 8'h00;
            o_test_cond <= 1'b0;
        end else begin
            if (!i_ctl.stack_file_enable_n) begin
                depth <= i_ctl.stack_direction ? depth + 4'h1 : depth - 4'h1;
            end
            case ({i_ctl.loop_counter_load_n, i_ctl.loop_counter_count_n})
                2'b01: count <= 8'(LOAD_VAL);
                2'b10: count <= count - 8'h01;
                2'b00: count <= 8'h00;
                default: ;
            endcase
            o_test_cond <= i_cond;
        end
    end
endmodule // nacd_seq_model

// ### dv/nacd_tb_top.sv
// self-checking bench of the next-address control decoder
`timescale 1ns/1ps
`include "nacd_defs.svh"
module nacd_tb_top;
    import nacd_pkg::*;
    logic        i_clk_sys, i_rst, i_hsel, i_hwrite, i_hready, i_test_cond;
    logic        cond_cmd, o_hreadyout, o_hresp;
    logic [1:0]  i_htrans;
    logic [2:0]  i_hsize;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
    nacd_ctl_s   o_ctl;
    logic [7:0]  seq_count;
    logic [3:0]  seq_depth;
    int          fail_count, total_checks;
    localparam int LOAD_VAL = 5;
    assign i_hready = o_hreadyout;
    nacd_top u_dut (.i_clk_sys, .i_rst, .i_test_cond, .i_hsel, .i_haddr,
        .i_htrans, .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hrdata,
        .o_hreadyout, .o_hresp, .o_ctl);
    nacd_seq_model #(.LOAD_VAL(LOAD_VAL)) u_seq (.i_clk_sys, .i_rst,
        .i_ctl(o_ctl), .i_cond(cond_cmd), .o_test_cond(i_test_cond),
        .o_count(seq_count), .o_depth(seq_depth));
    // ====
    function automatic nacd_ctl_s exp_ctl(input nacd_instr_e c, input logic t);
        logic [1:0] s, k, n, e;
        s = 2'b00;
        k = 2'b11;
        n = 2'b11;
        e = 2'b10;
        case (c)
            reset_to_zero_jump: begin s = 2'b11; n = 2'b00; end
            cond_jump_subroutine_direct: begin s = {t, t}; k = t ? 2'b01 : 2'b11; end
            jump_mapped: begin s = 2'b11; e = 2'b01; end
            cond_jump_direct: s = {t, t};
            push_cond_load: begin k = 2'b01; n = t ? 2'b01 : 2'b11; end
            cond_call_reg_or_direct: begin s = {t, 1'b1}; k = 2'b01; end
            cond_jump_vector: begin s = {t, t}; e = 2'b11; end
            cond_jump_reg_or_direct: s = {t, 1'b1};
            repeat_stack_loop: begin s = {~t, 1'b0}; k = {~t, ~t}; n = {1'b1, t}; end
            repeat_direct_loop: begin s = {~t, ~t}; n = {1'b1, t}; end
            cond_return: begin s = {t, 1'b0}; k = {~t, ~t}; end
            cond_jump_and_drop: begin s = {t, t}; k = {~t, ~t}; end
            load_count_continue: n = 2'b01;
            test_end_loop: begin s = {~t, 1'b0}; k = {~t, ~t}; end
            jump_direct: s = 2'b11;
            default: ;
        endcase
        return {s, k, n, e};
    endfunction
    task automatic check8(input string w, input nacd_ctl_s e, input nacd_ctl_s s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic check32(input string w, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ====
    // one single transfer; the wait is bounded by the bench
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        i_hsel <= 1'b1;
        i_htrans <= `NACD_HTRANS_NONSEQ;
        i_haddr <= a;
        i_hwrite <= w;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_hreadyout !== 1'b1 && n < 50);
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= d;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_hreadyout !== 1'b1 && n < 50);
        rd = o_hrdata;
        if (o_hreadyout !== 1'b1) begin
            fail_count++;
            give_verdict();
        end
    endtask
    task automatic test_reset();
        check8("reset ctl", exp_ctl(reset_to_zero_jump, 1'b0), o_ctl);
        bus(1'b0, `NACD_CTRL_OFS, 32'h0);
        check32("ctrl reset", 32'h0, rd);
        bus(1'b0, 32'h0000_0008, 32'h0);
        check32("unmapped", 32'h0, rd);
        $display("test_reset done");
    endtask
    task automatic test_codes();
        nacd_ctl_s e;
        logic [31:0] x;
        for (int i = 0; i < 32; i++) begin
            e = exp_ctl(nacd_instr_e'(i[3:0]), i[4]);
            bus(1'b1, `NACD_CTRL_OFS, {27'h0, i[4:0]});
            repeat (2) @(negedge i_clk_sys);
            check8("decode", e, o_ctl);
            bus(1'b0, `NACD_STAT_OFS, 32'h0);
            x = {16'h0, i[3:0], 3'h0, i[4], e[0], e[1], e[2], e[3], e[4],
                e[5], e[7], e[6]};
            check32("stat", x, rd);
        end
        $display("test_codes done");
    endtask
    task automatic test_pin();
        for (int i = 0; i < 32; i++) begin
            @(posedge i_clk_sys);
            cond_cmd <= i[4];
            bus(1'b1, `NACD_CTRL_OFS, {26'h0, 2'b10, i[3:0]});
            repeat (5) @(negedge i_clk_sys);
            check8("pin decode", exp_ctl(nacd_instr_e'(i[3:0]), i[4]), o_ctl);
        end
        bus(1'b1, `NACD_CTRL_OFS, 32'h0000_0002);
        bus(1'b1, `NACD_CTRL_OFS, 32'h0000_000F);
        repeat (2) @(negedge i_clk_sys);
        check8("back to back", exp_ctl(jump_direct, 1'b0), o_ctl);
        $display("test_pin done");
    endtask
    // partner state: counter load, hold and clear, stack hold
    task automatic test_model();
        logic [3:0] d;
        bus(1'b1, `NACD_CTRL_OFS, 32'h0000_000C);
        repeat (3) @(negedge i_clk_sys);
        check32("loaded count", 32'(LOAD_VAL), {24'h0, seq_count});
        bus(1'b1, `NACD_CTRL_OFS, 32'h0000_000E);
        repeat (3) @(negedge i_clk_sys);
        d = seq_depth;
        repeat (4) @(negedge i_clk_sys);
        check32("held count", 32'(LOAD_VAL), {24'h0, seq_count});
        check32("held depth", {28'h0, d}, {28'h0, seq_depth});
        bus(1'b1, `NACD_CTRL_OFS, 32'h0000_0000);
        repeat (3) @(negedge i_clk_sys);
        check32("cleared count", 32'h0, {24'h0, seq_count});
        $display("test_model done");
    endtask
    // ====
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        i_rst = 1'b1;
        i_hsel = 1'b0;
        i_htrans = 2'h0;
        i_haddr = 32'h0;
        i_hwrite = 1'b0;
        i_hsize = 3'h2;
        i_hwdata = 32'h0;
        cond_cmd = 1'b0;
        fail_count = 0;
        total_checks = 0;
        repeat (20) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        repeat (2) @(negedge i_clk_sys);
        test_reset();
        test_codes();
        test_pin();
        test_model();
        give_verdict();
    end
endmodule // nacd_tb_top
bind nacd_top nacd_checker u_chk (.i_clk_sys, .i_rst, .i_hsel, .i_haddr,
    .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hresp, .o_ctl);

// ### shared/nacd_defs.svh
// offsets, field positions, reset values and codes of the decoder block
`ifndef NACD_DEFS_SVH
`define NACD_DEFS_SVH

// ==========================================================================
// register map (byte addresses)
`define NACD_CTRL_OFS       32'h0000_0000
`define NACD_STAT_OFS       32'h0000_0004
`define NACD_ADDR_MSB       7

// ==========================================================================
// control register fields
`define NACD_CTRL_INSTR_LSB 0
`define NACD_CTRL_INSTR_MSB 3
`define NACD_CTRL_TEST_BIT  4
`define NACD_CTRL_TSEL_BIT  5
`define NACD_CTRL_RST       6'h00

// ==========================================================================
// status register fields
`define NACD_STAT_SRC_LSB   0
`define NACD_STAT_FILE_BIT  2
`define NACD_STAT_DIR_BIT   3
`define NACD_STAT_LDN_BIT   4
`define NACD_STAT_CEN_BIT   5
`define NACD_STAT_MAP_BIT   6
`define NACD_STAT_PL_BIT    7
`define NACD_STAT_TEST_BIT  8
`define NACD_STAT_INSTR_LSB 12

// ==========================================================================
// control output reset: sources direct, stack and counter hold
`define NACD_CTL_RST        8'hFC

// ==========================================================================
// bus codes
`define NACD_HTRANS_NONSEQ  2'h2
`define NACD_HTRANS_SEQ     2'h3
`define NACD_HRESP_OKAY     1'h0

`endif

// ### shared/nacd_pkg.sv
// types shared by the next-address control decoder files
package nacd_pkg;

    // ======================================================================
    // instruction codes, in code order 0 to 15
    typedef enum logic [3:0] {
        reset_to_zero_jump,
        cond_jump_subroutine_direct,
        jump_mapped,
        cond_jump_direct,
        push_cond_load,
        cond_call_reg_or_direct,
        cond_jump_vector,
        cond_jump_reg_or_direct,
        repeat_stack_loop,
        repeat_direct_loop,
        cond_return,
        cond_jump_and_drop,
        load_count_continue,
        test_end_loop,
        sequential_next,
        jump_direct
    } nacd_instr_e;

    // ======================================================================
    // decoder input and output bundles
    typedef struct packed {
        nacd_instr_e instr;
        logic        test;
    } nacd_cmd_s;

    typedef struct packed {
        logic source_select_high;
        logic source_select_low;
        logic stack_file_enable_n;
        logic stack_direction;
        logic loop_counter_load_n;
        logic loop_counter_count_n;
        logic map_source_enable_n;
        logic pipeline_source_enable_n;
    } nacd_ctl_s;

endpackage

// ### verilog/nacd_core.sv
// combinational next-address control decode core
`timescale 1ns/1ps
module nacd_core (
    input  wire nacd_pkg::nacd_cmd_s i_cmd,
    output      nacd_pkg::nacd_ctl_s o_ctl
);
    import nacd_pkg::*;

    // ======================================================================
    // truth table
    // msb first: sources, stack, counter, then the two source enables
    function automatic nacd_ctl_s nacd_decode(input nacd_cmd_s c);
        nacd_ctl_s r;
        logic      t;
        t = c.test;
        r = 8'hFC;
        r.source_select_high       = 1'b0;
        r.source_select_low        = 1'b0;
        r.map_source_enable_n      = 1'b1;
        r.pipeline_source_enable_n = 1'b0;
        unique case (c.instr)
            reset_to_zero_jump: begin
                {r.source_select_high, r.source_select_low} = 2'h3;
                r.loop_counter_load_n  = 1'b0;
                r.loop_counter_count_n = 1'b0;
            end
            cond_jump_subroutine_direct: begin
                {r.source_select_high, r.source_select_low} = {t, t};
                r.stack_file_enable_n = ~t;
            end
            jump_mapped: begin
                {r.source_select_high, r.source_select_low} = 2'h3;
                r.map_source_enable_n      = 1'b0;
                r.pipeline_source_enable_n = 1'b1;
            end
            cond_jump_direct: begin
                {r.source_select_high, r.source_select_low} = {t, t};
            end
            push_cond_load: begin
                r.stack_file_enable_n = 1'b0;
                r.loop_counter_load_n = ~t;
            end
            cond_call_reg_or_direct: begin
                {r.source_select_high, r.source_select_low} = {t, 1'b1};
                r.stack_file_enable_n = 1'b0;
            end
            cond_jump_vector: begin
                {r.source_select_high, r.source_select_low} = {t, t};
                r.pipeline_source_enable_n = 1'b1;
            end
            cond_jump_reg_or_direct: begin
                {r.source_select_high, r.source_select_low} = {t, 1'b1};
            end
            repeat_stack_loop: begin
                // low test: stack top and decrement; high: pop and fall out
                {r.source_select_high, r.source_select_low} = {~t, 1'b0};
                r.stack_file_enable_n  = ~t;
                r.stack_direction      = ~t;
                r.loop_counter_count_n = t;
            end
            repeat_direct_loop: begin
                {r.source_select_high, r.source_select_low} = {~t, ~t};
                r.loop_counter_count_n = t;
            end
            cond_return: begin
                {r.source_select_high, r.source_select_low} = {t, 1'b0};
                r.stack_file_enable_n = ~t;
                r.stack_direction     = ~t;
            end
            cond_jump_and_drop: begin
                {r.source_select_high, r.source_select_low} = {t, t};
                r.stack_file_enable_n = ~t;
                r.stack_direction     = ~t;
            end
            load_count_continue: begin
                r.loop_counter_load_n = 1'b0;
            end
            test_end_loop: begin
                {r.source_select_high, r.source_select_low} = {~t, 1'b0};
                r.stack_file_enable_n = ~t;
                r.stack_direction     = ~t;
            end
            sequential_next: begin
                r.pipeline_source_enable_n = 1'b0;
            end
            jump_direct: begin
                {r.source_select_high, r.source_select_low} = 2'h3;
            end
        endcase
        return r;
    endfunction

    // no storage here: pure gates between command and controls
    assign o_ctl = nacd_decode(i_cmd);

endmodule // nacd_core

// ### verilog/nacd_top.sv
// next-address control decoder with ahb-lite control and status registers
//
// Operation
// - zero jump: direct, hold, counter both low
// - subroutine call: low pc, high direct push
// - mapped jump: direct, map on, pipeline off
// - conditional jump: low pc, high direct
// - call register/direct always pushes, low register
// - push always, load counter on high test
// - vector jump: pc/direct, map and pipeline off
// - jump register on low, direct on high
// - stack loop: low top+decrement, high pc+pop
// - direct loop: low direct+decrement, high pc
// - return: low pc hold, high top+pop
// - jump and drop: low pc, high direct+pop
// - load counter, continue with pc
// - end loop: low top, high pc+pop
// - continue: pc, all held, pipeline on
// - jump: direct, all held, pipeline on
// - source select codes pc/reg/stack/direct
// - stack enable high holds, low+high pushes
// - counter codes hold, load, decrement
// - sixteen instructions from code and test
// - decode core is combinational, o_ctl is registered one cycle later
`timescale 1ns/1ps
`include "nacd_defs.svh"
module nacd_top (
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst,
    input  wire logic                i_test_cond,
    input  wire logic                i_hsel,
    input  wire logic [31:0]         i_haddr,
    input  wire logic [1:0]          i_htrans,
    input  wire logic                i_hwrite,
    input  wire logic [2:0]          i_hsize,
    input  wire logic [31:0]         i_hwdata,
    input  wire logic                i_hready,
    output      logic [31:0]         o_hrdata,
    output      logic                o_hreadyout,
    output      logic                o_hresp,
    output      nacd_pkg::nacd_ctl_s o_ctl
);
    import nacd_pkg::*;

    // ======================================================================
    // test pin synchroniser
    logic      test_meta;
    logic      test_sync;
    logic      next_test_meta;
    logic      next_test_sync;

    always_comb begin
        next_test_meta = i_test_cond;
        next_test_sync = test_meta;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            test_meta <= 1'b0;
            test_sync <= 1'b0;
        end else begin
            test_meta <= next_test_meta;
            test_sync <= next_test_sync;
        end
    end

    // ======================================================================
    // bus address phase capture
    logic       ap_valid;
    logic       dp_write;
    logic [7:0] dp_addr;
    logic       next_dp_write;
    logic [7:0] next_dp_addr;

    assign ap_valid = i_hsel && i_hready &&
                      (i_htrans == `NACD_HTRANS_NONSEQ ||
                       i_htrans == `NACD_HTRANS_SEQ);

    always_comb begin
        next_dp_write = ap_valid && i_hwrite;
        next_dp_addr  = ap_valid ? i_haddr[`NACD_ADDR_MSB:0] : dp_addr;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end else begin
            dp_write <= next_dp_write;
            dp_addr  <= next_dp_addr;
        end
    end

    // ======================================================================
    // control register: instruction, soft test bit, test source select
    logic [5:0] ctrl;
    logic [5:0] next_ctrl;

    always_comb begin
        next_ctrl = ctrl;
        if (dp_write && {24'h000000, dp_addr} == `NACD_CTRL_OFS) begin
            next_ctrl = i_hwdata[5:0];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ctrl <= `NACD_CTRL_RST;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ======================================================================
    // decode
    nacd_cmd_s cmd;
    nacd_ctl_s dec;

    always_comb begin
        cmd.instr = nacd_instr_e'(ctrl[`NACD_CTRL_INSTR_MSB:
                                       `NACD_CTRL_INSTR_LSB]);
        // pin test is used only when selected; soft bit aids bring-up
        cmd.test  = ctrl[`NACD_CTRL_TSEL_BIT] ? test_sync
                                               : ctrl[`NACD_CTRL_TEST_BIT];
    end

    nacd_core u_core (
        .i_cmd (cmd),
        .o_ctl (dec)
    );

    // ======================================================================
    // outputs and read data, all registered
    // trade-off: one cycle of latency buys glitch-free output pins
    logic [31:0] stat;
    nacd_ctl_s   next_ctl;
    logic [31:0] next_hrdata;

    always_comb begin
        stat = 32'h0000_0000;
        stat[`NACD_STAT_SRC_LSB+1] = dec.source_select_high;
        stat[`NACD_STAT_SRC_LSB]   = dec.source_select_low;
        stat[`NACD_STAT_FILE_BIT]  = dec.stack_file_enable_n;
        stat[`NACD_STAT_DIR_BIT]   = dec.stack_direction;
        stat[`NACD_STAT_LDN_BIT]   = dec.loop_counter_load_n;
        stat[`NACD_STAT_CEN_BIT]   = dec.loop_counter_count_n;
        stat[`NACD_STAT_MAP_BIT]   = dec.map_source_enable_n;
        stat[`NACD_STAT_PL_BIT]    = dec.pipeline_source_enable_n;
        stat[`NACD_STAT_TEST_BIT]  = cmd.test;
        stat[`NACD_STAT_INSTR_LSB +: 4] = cmd.instr;
        next_ctl    = dec;
        next_hrdata = o_hrdata;
        if (ap_valid && !i_hwrite) begin
            // unmapped reads answer zero
            if (i_haddr == `NACD_CTRL_OFS) begin
                next_hrdata = {26'h0000000, next_ctrl};
            end else if (i_haddr == `NACD_STAT_OFS) begin
                next_hrdata = stat;
            end else begin
                next_hrdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_ctl       <= `NACD_CTL_RST;
            o_hrdata    <= 32'h0000_0000;
            o_hreadyout <= 1'b0;
            o_hresp     <= `NACD_HRESP_OKAY;
        end else begin
            o_ctl       <= next_ctl;
            o_hrdata    <= next_hrdata;
            o_hreadyout <= 1'b1;
            o_hresp     <= `NACD_HRESP_OKAY;
        end
    end

endmodule // nacd_top
